// ==== logic/drs_sequencer.sv ====
// Module: hardware-reset front end and release sequencer
//
// Functional notes
// - Lows under 5 us ignored, over 9 us full reset; host holds 10 us.
// - Short high glitches inside a valid low pulse neither end nor restart it.
// - Each release reloads ID, electrode level and settings from storage.
// - Release sequence ends within 5 ms if sleeping, 120 ms if awake.
// - Reset while awake runs a blanking sequence of at most 120 ms.
// - Reset while sleeping keeps the display blank throughout.
// - Completed reset puts registers and modes in their default state.
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer
  import drs_pkg::*;
#(
  parameter int unsigned SLEEP_CYC = CANCEL_SLEEP_CYC,
  parameter int unsigned AWAKE_CYC = CANCEL_AWAKE_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              hw_reset_line_n,
  input  wire logic              sleep_in,
  input  wire logic [NVM_DW-1:0] nvm_rdata,
  output var  logic [NVM_AW-1:0] nvm_addr,
  output var  logic              nvm_rd,
  output var  logic              core_reset,
  output var  logic              display_blank,
  output var  logic              blank_seq,
  output var  logic              busy,
  output var  logic              cmd_ready,
  output var  logic              wake_ready,
  output var  logic [NVM_DW-1:0] common_electrode_level,
  output var  logic [NVM_DW*NVM_WORDS-1:0] cfg_image
);
  logic              filt_low;
  drs_state_t        state;
  drs_state_t        next_state;
  logic [31:0]       cnt;
  logic [31:0]       next_cnt;
  logic [31:0]       since_rel;
  logic [31:0]       next_since_rel;
  logic [NVM_AW-1:0] next_nvm_addr;
  logic              next_nvm_rd;
  logic              rd_pend;
  logic              next_rd_pend;
  logic              was_awake;
  logic              next_was_awake;
  logic              next_core_reset;
  logic              next_display_blank;
  logic              next_blank_seq;
  logic              next_cmd_ready;
  logic              next_wake_ready;
  logic [NVM_DW-1:0] next_level;
  logic [NVM_DW*NVM_WORDS-1:0] next_cfg;

  // Saturating increment shared by both timers
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (v == 32'hFFFFFFFF) ? v : v + 32'h00000001;
  endfunction

  // Spike filter sits in front of width measurement
  drs_filter #(
    .GLITCH_CYC (REJECT_CYC)
  ) drs_filter_inst (
    .core_clk (core_clk),
    .srst     (srst),
    .raw_low  (~hw_reset_line_n),
    .filt_low (filt_low)
  );

  // Sequencer next state
  always_comb begin
    next_state         = state;
    next_cnt           = sat_inc(cnt);
    next_since_rel     = sat_inc(since_rel);
    next_nvm_addr      = nvm_addr;
    next_nvm_rd        = 1'b0;
    next_rd_pend       = nvm_rd;
    next_was_awake     = was_awake;
    next_core_reset    = core_reset;
    next_display_blank = display_blank;
    next_blank_seq     = blank_seq;
    next_cmd_ready     = cmd_ready;
    next_wake_ready    = wake_ready;
    next_level         = common_electrode_level;
    next_cfg           = cfg_image;
    case (state)
      DRS_IDLE: begin
        if (filt_low) begin
          // Filter already spent REJECT_CYC; count on from there
          next_state     = DRS_LOW;
          next_cnt       = 32'(REJECT_CYC);
          next_was_awake = ~sleep_in;
          next_core_reset = 1'b1;
          next_display_blank = 1'b1;
          next_blank_seq = ~sleep_in;
          next_cmd_ready = 1'b0;
          next_wake_ready = 1'b0;
        end
      end
      DRS_LOW: begin
        // Filtered level, so brief highs do not end the pulse
        if (!filt_low) begin
          // A started reset (5..9 us) still proceeds to release
          next_state = DRS_LOAD;
          next_cnt   = 32'h00000000;
          next_since_rel = 32'h00000000;
          next_nvm_addr = '0;
          next_nvm_rd = 1'b1;
        end else if (cnt >= 32'(FULL_CYC)) begin
          next_state = DRS_HELD;
        end
      end
      DRS_HELD: begin
        if (!filt_low) begin
          next_state     = DRS_LOAD;
          next_cnt       = 32'h00000000;
          next_since_rel = 32'h00000000;
          next_nvm_addr  = '0;
          next_nvm_rd    = 1'b1;
        end
      end
      DRS_LOAD: begin
        // One word per two cycles: address, then capture
        if (rd_pend) begin
          next_cfg[nvm_addr*NVM_DW +: NVM_DW] = nvm_rdata;
          if (nvm_addr == LEVEL_IDX) begin
            next_level = nvm_rdata;
          end
          if (nvm_addr == NVM_AW'(NVM_WORDS - 1)) begin
            next_state = DRS_WAIT;
            next_core_reset = 1'b0;
          end else begin
            next_nvm_addr = nvm_addr + NVM_AW'(1);
            next_nvm_rd   = 1'b1;
          end
        end
      end
      DRS_WAIT: begin
        // Awake start gets the longer blanking interval
        if (since_rel >= 32'(SLEEP_CYC - 1)) begin
          next_cmd_ready = 1'b1;
          if (!was_awake) begin
            next_display_blank = 1'b1;
            next_state = DRS_IDLE;
          end
        end
        if (since_rel >= 32'(AWAKE_CYC - 1)) begin
          next_wake_ready = 1'b1;
          next_blank_seq  = 1'b0;
          next_state      = DRS_IDLE;
        end
      end
      default: begin
        next_state = DRS_IDLE;
      end
    endcase
    // A new pulse during release restarts from scratch
    if (state != DRS_IDLE && state != DRS_LOW && state != DRS_HELD && filt_low) begin
      next_state      = DRS_LOW;
      next_cnt        = 32'(REJECT_CYC);
      next_core_reset = 1'b1;
      // Blanking kind follows the sleep state at this new start
      next_was_awake  = ~sleep_in;
      next_display_blank = 1'b1;
      next_blank_seq  = ~sleep_in;
      next_cmd_ready  = 1'b0;
      next_wake_ready = 1'b0;
      next_nvm_rd     = 1'b0;
    end
  end

  // Registers; defaults are the hardware-reset condition
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state                  <= DRS_IDLE;
      cnt                    <= 32'h00000000;
      since_rel              <= 32'h00000000;
      nvm_addr               <= '0;
      nvm_rd                 <= 1'b0;
      rd_pend                <= 1'b0;
      was_awake              <= 1'b0;
      core_reset             <= 1'b0;
      busy                   <= 1'b0;
      display_blank          <= 1'b1;
      blank_seq              <= 1'b0;
      cmd_ready              <= 1'b1;
      wake_ready             <= 1'b1;
      common_electrode_level <= CFG_RESET;
      cfg_image              <= '0;
    end else begin
      state                  <= next_state;
      cnt                    <= next_cnt;
      since_rel              <= next_since_rel;
      nvm_addr               <= next_nvm_addr;
      nvm_rd                 <= next_nvm_rd;
      rd_pend                <= next_rd_pend;
      was_awake              <= next_was_awake;
      core_reset             <= next_core_reset;
      busy                   <= next_core_reset;
      display_blank          <= next_display_blank;
      blank_seq              <= next_blank_seq;
      cmd_ready              <= next_cmd_ready;
      wake_ready             <= next_wake_ready;
      common_electrode_level <= next_level;
      cfg_image              <= next_cfg;
    end
  end
endmodule // drs_sequencer
`default_nettype wire

// ==== common/drs_pkg.sv ====
// Package: constants and types for the display reset sequencer
package drs_pkg;
  localparam int unsigned CLK_MHZ            = 250;
  // Spike filter and full-reset width limits, in ns
  localparam int unsigned REJECT_NS          = 5000;
  localparam int unsigned FULL_NS            = 9000;
  // Reset-cancel intervals, in us
  localparam int unsigned CANCEL_SLEEP_US    = 5000;
  localparam int unsigned CANCEL_AWAKE_US    = 120000;
  // Cycle counts derived from the clock rate
  localparam int unsigned REJECT_CYC         = REJECT_NS * CLK_MHZ / 1000;
  localparam int unsigned FULL_CYC           = (FULL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CANCEL_SLEEP_CYC   = CANCEL_SLEEP_US * CLK_MHZ;
  localparam int unsigned CANCEL_AWAKE_CYC   = CANCEL_AWAKE_US * CLK_MHZ;
  // Nonvolatile load image size and word width
  localparam int unsigned NVM_WORDS          = 8;
  localparam int unsigned NVM_AW             = 3;
  localparam int unsigned NVM_DW             = 8;
  // Word index of the common-electrode level in the image
  localparam logic [2:0]  LEVEL_IDX          = 3'h3;
  // Value after reset of loaded registers
  localparam logic [7:0]  CFG_RESET          = 8'h00;

  typedef enum logic [4:0] {
    DRS_IDLE  = 5'b00001,
    DRS_LOW   = 5'b00010,
    DRS_HELD  = 5'b00100,
    DRS_LOAD  = 5'b01000,
    DRS_WAIT  = 5'b10000
  } drs_state_t;
endpackage : drs_pkg

// ==== logic/drs_filter.sv ====
// Module: pulse-width spike filter for the reset line
`timescale 1ns/1ps
`default_nettype none
module drs_filter
  import drs_pkg::*;
#(
  parameter int unsigned GLITCH_CYC = REJECT_CYC
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic raw_low,
  output var  logic filt_low
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_filt_low;

  // Level changes only after it holds for GLITCH_CYC cycles
  always_comb begin
    next_cnt      = 16'h0000;
    next_filt_low = filt_low;
    if (raw_low != filt_low) begin
      if (cnt >= 16'(GLITCH_CYC - 1)) begin
        next_filt_low = raw_low;
      end else begin
        next_cnt = cnt + 16'h0001;
      end
    end
  end

  // State registers; idle output matches the high idle line
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt      <= 16'h0000;
      filt_low <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      filt_low <= next_filt_low;
    end
  end
endmodule // drs_filter
`default_nettype wire

// ==== sim/drs_sequencer_checker.sv ====
// Port-level assertions for the display reset sequencer
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer_checker
  import drs_pkg::*;
#(
  parameter int unsigned SLEEP_CYC = CANCEL_SLEEP_CYC,
  parameter int unsigned AWAKE_CYC = CANCEL_AWAKE_CYC
) (
  input wire logic                        core_clk,
  input wire logic                        srst,
  input wire logic                        hw_reset_line_n,
  input wire logic                        sleep_in,
  input wire logic [NVM_AW-1:0]           nvm_addr,
  input wire logic                        nvm_rd,
  input wire logic                        core_reset,
  input wire logic                        display_blank,
  input wire logic                        blank_seq,
  input wire logic                        busy,
  input wire logic                        cmd_ready,
  input wire logic                        wake_ready,
  input wire logic [NVM_DW-1:0]           common_electrode_level,
  input wire logic [NVM_DW*NVM_WORDS-1:0] cfg_image
);
  int unsigned wait_cnt;
  int unsigned next_wait_cnt;
  // Cycles spent after the load before commands are allowed
  always_comb next_wait_cnt = (cmd_ready || core_reset) ? 0 : wait_cnt + 1;
  always_ff @(posedge core_clk) wait_cnt <= srst ? 0 : next_wait_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence reset_begins; $rose(core_reset); endsequence
  sequence two_reads; nvm_rd ##2 nvm_rd; endsequence
  low_filter_a: assert property (reset_begins |-> !$past(hw_reset_line_n) && !$past(hw_reset_line_n, 2))
    else $error("core reset began without a held low");
  blank_hold_a: assert property (core_reset |-> display_blank && !cmd_ready && !wake_ready)
    else $error("blank or ready wrong during reset");
  blank_kind_a: assert property (reset_begins |-> blank_seq == !$past(sleep_in))
    else $error("blanking kind does not follow sleep state");
  busy_mirror_a: assert property (busy == core_reset)
    else $error("busy differs from core reset");
  rd_pulse_a: assert property (nvm_rd |=> !nvm_rd)
    else $error("read strobe longer than one cycle");
  rd_in_reset_a: assert property (nvm_rd |-> core_reset)
    else $error("storage read outside reset");
  addr_step_a: assert property (two_reads |-> nvm_addr == $past(nvm_addr, 2) + 3'h1)
    else $error("storage address not stepping by one");
  level_copy_a: assert property ($fell(core_reset) |-> common_electrode_level == cfg_image[NVM_DW*LEVEL_IDX +: NVM_DW])
    else $error("electrode level differs from image word");
  wake_hold_a: assert property ($rose(wake_ready) |-> !blank_seq && !core_reset && cmd_ready)
    else $error("wake readiness before blanking ended");
  cmd_bound_a: assert property (wait_cnt <= SLEEP_CYC)
    else $error("command readiness late");
endmodule // drs_sequencer_checker
bind drs_sequencer drs_sequencer_checker #(.SLEEP_CYC(SLEEP_CYC), .AWAKE_CYC(AWAKE_CYC))
  drs_sequencer_checker_inst (.core_clk(core_clk), .srst(srst), .hw_reset_line_n(hw_reset_line_n),
  .sleep_in(sleep_in), .nvm_addr(nvm_addr), .nvm_rd(nvm_rd), .core_reset(core_reset),
  .display_blank(display_blank), .blank_seq(blank_seq), .busy(busy), .cmd_ready(cmd_ready),
  .wake_ready(wake_ready), .common_electrode_level(common_electrode_level),
  .cfg_image(cfg_image));
`default_nettype wire

// ==== sim/drs_host_model.sv ====
// Host and storage model facing the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module drs_host_model
  import drs_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              nvm_rd,
  input  wire logic [NVM_AW-1:0] nvm_addr,
  output var  logic              hw_reset_line_n,
  output var  logic [NVM_DW-1:0] nvm_rdata
);
  logic [NVM_DW-1:0] mem [NVM_WORDS];
  initial hw_reset_line_n = 1'b1;
  initial nvm_rdata = 8'h00;
  // Data a cycle after the strobe; toggles otherwise so stale data never looks valid
  always @(posedge core_clk) nvm_rdata <= nvm_rd ? mem[nvm_addr] : ~nvm_rdata;
  // Low pulse, optional high spike inside, then release
  task automatic pulse(input int lo1, input int spk, input int lo2);
    hw_reset_line_n = 1'b0;
    repeat (lo1) @(posedge core_clk);
    #1 hw_reset_line_n = (spk == 0) ? 1'b0 : 1'b1;
    repeat (spk) @(posedge core_clk);
    #1 hw_reset_line_n = 1'b0;
    repeat (lo2) @(posedge core_clk);
    #1 hw_reset_line_n = 1'b1;
  endtask
endmodule // drs_host_model
`default_nettype wire

// ==== sim/drs_sequencer_bench.sv ====
// Self-checking bench for the display reset sequencer
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer_bench
  import drs_pkg::*;
;
  localparam int unsigned SLP = 2000;
  localparam int unsigned AWK = 4000;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic sleep_in = 1'b0;
  logic line_n, nvm_rd, core_reset, display_blank, blank_seq, busy, cmd_ready, wake_ready;
  logic [NVM_AW-1:0] nvm_addr;
  logic [NVM_DW-1:0] nvm_rdata, level;
  logic [63:0] cfg_image, exp_img;
  logic [63:0] img_q [$];
  logic core_prev = 1'b0;
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 32'h8d67;
  always #2 core_clk = ~core_clk;
  drs_sequencer #(.SLEEP_CYC(SLP), .AWAKE_CYC(AWK)) drs_sequencer_inst (.core_clk(core_clk),
    .srst(srst), .hw_reset_line_n(line_n), .sleep_in(sleep_in), .nvm_rdata(nvm_rdata),
    .nvm_addr(nvm_addr), .nvm_rd(nvm_rd), .core_reset(core_reset), .display_blank(display_blank),
    .blank_seq(blank_seq), .busy(busy), .cmd_ready(cmd_ready), .wake_ready(wake_ready),
    .common_electrode_level(level), .cfg_image(cfg_image));
  drs_host_model drs_host_model_inst (.core_clk(core_clk), .nvm_rd(nvm_rd),
    .nvm_addr(nvm_addr), .hw_reset_line_n(line_n), .nvm_rdata(nvm_rdata));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Oldest noted image is compared when a load finishes
  always @(negedge core_clk) begin
    core_prev <= core_reset;
    if (core_prev === 1'b1 && core_reset === 1'b0) begin
      exp_img = img_q.pop_front();
      check("cfg_image", cfg_image, exp_img);
      check("level", {56'h0, level}, {56'h0, exp_img[31:24]});
    end
  end
  // Full reset with fresh storage contents; awake runs carry a spike
  task automatic run_reset(input logic slp, input int spk);
    logic [63:0] img;
    for (int i = 0; i < NVM_WORDS; i++) begin
      drs_host_model_inst.mem[i] = 8'($random(seed));
      img[8*i +: 8] = drs_host_model_inst.mem[i];
    end
    img_q.push_back(img);
    sleep_in = slp;
    drs_host_model_inst.pulse(1400, spk, 1200);
    check("core_reset", {63'h0, core_reset}, 64'h1);
    check("blank_seq", {63'h0, blank_seq}, {63'h0, ~slp});
    check("wake_ready", {63'h0, wake_ready}, 64'h0);
    wait_cyc(1250 + SLP - 30);
    check("cmd_ready low", {63'h0, cmd_ready}, 64'h0);
    wait_cyc(60);
    check("cmd_ready", {63'h0, cmd_ready}, 64'h1);
    check("blank", {61'h0, display_blank, core_reset, wake_ready}, 64'h4);
    // Wake flag rises AWK cycles after filtered release; look 30 cycles later
    wait_cyc(AWK - SLP);
    check("wake_ready", {62'h0, wake_ready, blank_seq}, {62'h0, ~slp, 1'b0});
    $display("test reset sleep=%0d done", slp);
  endtask
  initial begin
    wait_cyc(16);
    srst = 1'b0;
    check("after srst", {61'h0, core_reset, display_blank, cmd_ready}, 64'h3);
    drs_host_model_inst.pulse(1000, 0, 0);
    wait_cyc(1300);
    check("short pulse", {63'h0, core_reset}, 64'h0);
    $display("test short pulse done");
    run_reset(1'b0, 100);
    run_reset(1'b1, 0);
    finish_test();
  end
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end
endmodule // drs_sequencer_bench
`default_nettype wire
